/* File: include/ctd_pkg.sv */
// package: timing constants, states and carrier structs for the cable type detector
package ctd_pkg;
    localparam int unsigned CLK_HZ = 50000000;
    localparam int unsigned PULSE_MIN_US = 30;
    localparam int unsigned SAMPLE_MIN_US = 2;
    localparam int unsigned SAMPLE_MAX_US = 13;
    // least times round up, longest round down
    localparam int unsigned PULSE_CYC = (PULSE_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned SMIN_CYC = (SAMPLE_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned SMAX_CYC = (SAMPLE_MAX_US * (CLK_HZ / 1000)) / 1000;
    // sample at the middle of the window for margin on both sides
    localparam int unsigned SAMPLE_CYC = (SMIN_CYC + SMAX_CYC) / 2;
    localparam int unsigned CNT_W = 11;
    localparam int unsigned CBL_BIT = 13;
    localparam int unsigned CBL_WORD = 93;
    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_DRIVE = 4'h2,
        ST_WAIT = 4'h4,
        ST_DONE = 4'h8
    } ctd_state_t;

    typedef struct packed {
        logic out;
        logic oe;
    } ctd_pin_t;

    typedef struct packed {
        ctd_state_t st;
        logic [CNT_W-1:0] cnt;
        logic drive_r;
        logic cable80_r;
        logic done_r;
        logic sampled_r;
    } ctd_core_t;
endpackage

/* File: rtl/ctd_sync.sv */
// two-flop synchroniser for the cable identify line input
`timescale 1ns/1ps
module ctd_sync (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic d_in,
    output logic q_out
);
    typedef struct packed {
        logic s1;
        logic s2;
    } ctd_sync_t;
    ctd_sync_t st_r;
    ctd_sync_t st_nxt;
    always_comb
    begin
        st_nxt.s1 = d_in;
        st_nxt.s2 = st_r.s1;
    end
    // reset to high: the line idles pulled up
    always_ff @(posedge CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            st_r <= 2'h3;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign q_out = st_r.s2;
endmodule // ctd_sync

/* File: rtl/ctd_cable_detect.sv */
// cable type detect sequencer: pulses, releases and samples the cable identify line
`timescale 1ns/1ps
// Function
// - drive line low 30us before data
// - release, sample once 2-13us later
// - low sample reports bit 13 zero
// - high sample reports bit 13 one
// - second device releases line on identify
module ctd_cable_detect
    import ctd_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = PULSE_CYC,
    parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC
) (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic IDENTIFY_IN,
    input wire logic IS_SECOND_DEV_IN,
    input wire logic CABLE_ID_LINE_IN,
    output logic CABLE_ID_LINE_OUT,
    output logic CABLE_ID_LINE_OE_OUT,
    output logic CABLE80_OUT,
    output logic DONE_OUT,
    output logic BUSY_OUT
);
    import ctd_pkg::*;

    localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYCLES - 1);
    localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYCLES - 1);

    ctd_core_t c_r;
    ctd_core_t c_nxt;
    logic line_s;

    ctd_sync u_sync (
        .CLK_IN(CLK_IN),
        .RESETN_IN(RESETN_IN),
        .d_in(CABLE_ID_LINE_IN),
        .q_out(line_s)
    );

    always_comb
    begin
        c_nxt = c_r;
        c_nxt.sampled_r = 1'b0;
        case (c_r.st)
            ST_IDLE, ST_DONE:
            begin
                if (IDENTIFY_IN)
                begin
                    c_nxt.done_r = 1'b0;
                    c_nxt.cnt = CNT_ZERO;
                    if (IS_SECOND_DEV_IN)
                    begin
                        // the line stays released so the first device sees it clean
                        c_nxt.drive_r = 1'b0;
                        c_nxt.st = ST_DONE;
                        c_nxt.done_r = 1'b1;
                    end
                    else
                    begin
                        c_nxt.drive_r = 1'b1;
                        c_nxt.st = ST_DRIVE;
                    end
                end
            end
            ST_DRIVE:
            begin
                if (c_r.cnt == PULSE_LAST)
                begin
                    c_nxt.drive_r = 1'b0;
                    c_nxt.cnt = CNT_ZERO;
                    c_nxt.st = ST_WAIT;
                end
                else
                begin
                    c_nxt.cnt = c_r.cnt + 1'b1;
                end
            end
            ST_WAIT:
            begin
                // sample delay includes the two synchroniser cycles
                if (c_r.cnt == SAMPLE_LAST)
                begin
                    c_nxt.cable80_r = line_s;
                    c_nxt.sampled_r = 1'b1;
                    c_nxt.done_r = 1'b1;
                    c_nxt.st = ST_DONE;
                end
                else
                begin
                    c_nxt.cnt = c_r.cnt + 1'b1;
                end
            end
            default:
            begin
                c_nxt.st = ST_IDLE;
                c_nxt.drive_r = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            c_r <= '{st: ST_IDLE, cnt: CNT_ZERO, drive_r: 1'b0, cable80_r: 1'b0,
                     done_r: 1'b0, sampled_r: 1'b0};
        end
        else
        begin
            c_r <= c_nxt;
        end
    end

    // open drain: drive low only, output data always zero
    assign CABLE_ID_LINE_OUT = 1'b0;
    assign CABLE_ID_LINE_OE_OUT = c_r.drive_r;
    assign CABLE80_OUT = c_r.cable80_r;
    assign DONE_OUT = c_r.done_r;
    assign BUSY_OUT = c_r.drive_r | (c_r.st == ST_WAIT);

    int unsigned low_len;
    always_ff @(posedge CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            low_len <= 0;
        end
        else if (c_r.drive_r)
        begin
            low_len <= low_len + 1;
        end
        else
        begin
            low_len <= 0;
        end
    end

    // counts wait cycles so the sample delay check needs no long delay
    int unsigned wait_len;
    always_ff @(posedge CLK_IN)
    begin
        if (!RESETN_IN)
        begin
            wait_len <= 0;
        end
        else if (c_r.st == ST_WAIT)
        begin
            wait_len <= wait_len + 1;
        end
        else
        begin
            wait_len <= 0;
        end
    end

    chk_pulse_min_len: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        $fell(c_r.drive_r) |-> $past(low_len) >= PULSE_CYCLES - 1)
        else $error("drive pulse shorter than minimum");
    chk_no_done_driving: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        c_r.drive_r |-> !c_r.done_r)
        else $error("done while still driving line");
    chk_sample_window: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        c_r.sampled_r |-> wait_len == SAMPLE_CYCLES)
        else $error("sample not taken at planned delay");
    chk_single_sample: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        c_r.sampled_r |=> !c_r.sampled_r)
        else $error("more than one sample taken");
    chk_low_gives_zero: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        c_nxt.sampled_r && !line_s |=> !c_r.cable80_r)
        else $error("low sample not reported as zero");
    chk_high_gives_one: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        c_nxt.sampled_r && line_s |=> c_r.cable80_r)
        else $error("high sample not reported as one");
    chk_second_releases: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        IDENTIFY_IN && IS_SECOND_DEV_IN && !BUSY_OUT |=> !c_r.drive_r && c_r.done_r)
        else $error("second device drove the line");
    chk_released_in_wait: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
        c_r.st == ST_WAIT |-> !CABLE_ID_LINE_OE_OUT)
        else $error("line driven during sample wait");

    cov_cable80: cover property (@(posedge CLK_IN) c_r.sampled_r && c_r.cable80_r);
    cov_cable40: cover property (@(posedge CLK_IN) c_r.sampled_r && !c_r.cable80_r);
    cov_second: cover property (@(posedge CLK_IN) IDENTIFY_IN && IS_SECOND_DEV_IN);
endmodule // ctd_cable_detect

/* File: verif/ctd_line_model.sv */
// far side of the cable identify line: pull-up plus optional host capacitor
`timescale 1ns/1ps
module ctd_line_model #(
    parameter int unsigned RISE_CYCLES = 30
) (
    input wire logic clk_in,
    input wire logic drive_low_in,
    input wire logic cap_in,
    output logic line_out
);
    int unsigned rise_cnt;

    // a charged capacitor holds the released line low for a while
    always_ff @(posedge clk_in)
    begin
        if (drive_low_in)
        begin
            rise_cnt <= 0;
        end
        else if (rise_cnt < RISE_CYCLES)
        begin
            rise_cnt <= rise_cnt + 1;
        end
    end

    // released line goes to the pull-up level at once, or with cap_in stays low until rise_cnt reaches RISE_CYCLES
    assign line_out = !(drive_low_in || (cap_in && (rise_cnt < RISE_CYCLES)));
endmodule // ctd_line_model

/* File: verif/test_cable_type_detect_sequencer.sv */
// self-checking bench for the cable type detect sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin num_errors++; \
    $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module test_cable_type_detect_sequencer;
    localparam int unsigned PC = 20;
    localparam int unsigned SC = 8;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ident = 1'b0;
    logic second = 1'b0;
    logic cap = 1'b0;
    logic line, oe, out_q, c80, done, busy;
    int num_errors = 0;
    int checked = 0;

    initial forever #10 clk = ~clk;

    ctd_cable_detect #(.PULSE_CYCLES(PC), .SAMPLE_CYCLES(SC)) i_ctd_cable_detect (
        .CLK_IN(clk), .RESETN_IN(resetn), .IDENTIFY_IN(ident), .IS_SECOND_DEV_IN(second),
        .CABLE_ID_LINE_IN(line), .CABLE_ID_LINE_OUT(out_q), .CABLE_ID_LINE_OE_OUT(oe),
        .CABLE80_OUT(c80), .DONE_OUT(done), .BUSY_OUT(busy));

    ctd_line_model i_ctd_line_model (
        .clk_in(clk), .drive_low_in(oe && !out_q), .cap_in(cap), .line_out(line));

    task close_out;
        if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task identify(input logic sec);
        @(negedge clk);
        second = sec;
        ident = 1'b1;
        @(negedge clk);
        ident = 1'b0;
    endtask

    // the identify to the second device only frees the line and keeps the old report
    task second_dev(input logic old80);
        identify(1'b1);
        @(negedge clk);
        `CHK("done", 1'b1, done)
        `CHK("oe", 1'b0, oe)
        `CHK("cable80", old80, c80)
    endtask

    // full pulse, release and single sample on the first device
    task first_dev(input logic has_cap, input logic exp80);
        int n;
        int w;
        // the line has already stood low for one cycle when counting starts
        n = 1;
        w = 0;
        cap = has_cap;
        identify(1'b0);
        @(negedge clk);
        `CHK("busy", 1'b1, busy)
        `CHK("done", 1'b0, done)
        `CHK("line", 1'b0, line)
        `CHK("out", 1'b0, out_q)
        while (oe === 1'b1 && n < 100) begin n++; @(negedge clk); end
        `CHK("pulse", PC, n)
        while (done !== 1'b1 && w < 100) begin w++; @(negedge clk); end
        if (n == 100 || w == 100) begin num_errors++; close_out(); end
        `CHK("delay", SC, w)
        // host limits fast modes by this bit before set features
        `CHK("cable80", exp80, c80)
        `CHK("busy", 1'b0, busy)
    endtask

    initial
    begin
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        `CHK("reset", 1'b0, c80 | done | busy | oe)
        // host order after reset: second device first, then the first device
        second_dev(1'b0);
        first_dev(1'b1, 1'b0);
        first_dev(1'b0, 1'b1);
        second_dev(1'b1);
        close_out();
    end
endmodule // test_cable_type_detect_sequencer
